/* bench/exch_partner.sv */
// Purpose: Exchange engine stand-in that answers every open request.
// Assumes: One request open at a time, same clock as the block.
// Notes: Answers on the third cycle of a request; rsp is scrambled outside done.
module exch_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic xfer_valid,
    input wire link_ctrl_pkg::xfer_cmd_t xfer_cmd,
    input wire logic rsp_err,
    output logic xfer_done,
    output link_ctrl_pkg::xfer_rsp_t xfer_rsp,
    output logic [15:0] n_xfer,
    output link_ctrl_pkg::xfer_cmd_t last_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] age;
    assign xfer_done = xfer_valid && (age == 2'h2);
    // Inverted outside the done cycle, so a stray sample is caught
    assign xfer_rsp = xfer_done ? {rsp_err, rsp_err, 1'b1} : {~rsp_err, ~rsp_err, 1'b0};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age <= 2'h0;
            n_xfer <= 16'h0000;
            last_cmd <= '0;
        end else if (xfer_done) begin
            age <= 2'h0;
            n_xfer <= n_xfer + 16'h0001;
            last_cmd <= xfer_cmd;
        end else if (xfer_valid) begin
            age <= age + 2'h1;
        end
    end
endmodule

/* bench/tb_top.sv */
// Purpose: Self-checking bench of the link control flags over APB.
// Assumes: Zero-wait APB slave; partner answers each exchange.
// Notes: Waits are bounded; a spent bound counts as a mismatch.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rsp_err = 1'b0;
    logic xfer_valid;
    logic xfer_done;
    logic [15:0] n_xfer;
    logic [15:0] n0;
    logic [31:0] rd;
    link_ctrl_pkg::xfer_cmd_t xfer_cmd;
    link_ctrl_pkg::xfer_cmd_t last_cmd;
    link_ctrl_pkg::xfer_rsp_t xfer_rsp;
    int err_total = 0;
    int num_checks = 0;
    link_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xfer_cmd(xfer_cmd), .xfer_valid(xfer_valid),
        .xfer_done(xfer_done), .xfer_rsp(xfer_rsp));
    exch_partner far_end (.pclk(pclk), .presetn(presetn), .xfer_valid(xfer_valid),
        .xfer_cmd(xfer_cmd), .rsp_err(rsp_err), .xfer_done(xfer_done),
        .xfer_rsp(xfer_rsp), .n_xfer(n_xfer), .last_cmd(last_cmd));
    initial begin
        forever #5 pclk = ~pclk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Entered right after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk(32'h0000_0001, 32'h0000_0000);
            print_verdict();
        end
        rd = prdata;
        rd[31] = rd[31] | (pslverr === 1'b1 && a == 8'h40);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    // Polls one register bit until it reaches a level, bounded
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        int i;
        for (i = 0; i < 400; i++) begin
            apb(1'b0, a, 32'h0000_0000);
            if (rd[b] === v) break;
        end
        if (i == 400) begin
            chk(32'h0000_0001, 32'h0000_0000);
            print_verdict();
        end
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(link_ctrl_pkg::OFS_CTRL, 32'h0000_0000);
        rdchk(link_ctrl_pkg::OFS_STATUS, 32'h0000_0000);
        rdchk(link_ctrl_pkg::OFS_LIMIT, 32'h0000_0001);
        apb(1'b1, link_ctrl_pkg::OFS_STATUS, 32'hffff_ffff);
        rdchk(link_ctrl_pkg::OFS_STATUS, 32'h0000_0000);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(rd, 32'h8000_0000);
        apb(1'b1, link_ctrl_pkg::OFS_CTRL, 32'h0000_000d);
        rdchk(link_ctrl_pkg::OFS_STATUS, 32'h0000_0022);
        rdchk(link_ctrl_pkg::OFS_CTRL, 32'h0000_000c);
        apb(1'b1, link_ctrl_pkg::OFS_CTRL, 32'h0000_0000);
        apb(1'b1, link_ctrl_pkg::OFS_LIMIT, 32'h0000_0000);
        rdchk(link_ctrl_pkg::OFS_STATUS, 32'h0000_0030);
        rdchk(link_ctrl_pkg::OFS_LIMIT, 32'h0000_0000);
        apb(1'b1, link_ctrl_pkg::OFS_LIMIT, 32'h0000_0002);
        // Manual run of two full cycles with protocol, extension port and sync bits set
        n0 = n_xfer;
        apb(1'b1, link_ctrl_pkg::OFS_CTRL, 32'h0000_0199);
        wait_bit(link_ctrl_pkg::OFS_CTRL, 0, 1'b0);
        rdchk(link_ctrl_pkg::OFS_COUNT, 32'h0000_0002);
        rdchk(link_ctrl_pkg::OFS_CTRL, 32'h0000_0198);
        chk(32'(n_xfer - n0), 32'h0000_0040);
        chk(32'(last_cmd), {20'h0_0000, 8'h21, 4'b0111});
        // One selected slave only, answering with both errors
        apb(1'b1, link_ctrl_pkg::OFS_LIMIT, 32'h0000_0001);
        apb(1'b1, link_ctrl_pkg::OFS_CONNECT, 32'h0000_0004);
        rsp_err <= 1'b1;
        n0 = n_xfer;
        apb(1'b1, link_ctrl_pkg::OFS_CTRL, 32'h0000_000b);
        wait_bit(link_ctrl_pkg::OFS_CTRL, 0, 1'b0);
        chk(32'(n_xfer - n0), 32'h0000_0001);
        chk(32'(last_cmd.addr), 32'h0000_0004);
        rdchk(link_ctrl_pkg::OFS_STATUS, 32'h0000_002c);
        // Detection while stopped; the slot holding the master's address is skipped
        rsp_err <= 1'b0;
        apb(1'b1, link_ctrl_pkg::OFS_MASTER, 32'h0000_0005);
        n0 = n_xfer;
        apb(1'b1, link_ctrl_pkg::OFS_CTRL, 32'h0000_0020);
        wait_bit(link_ctrl_pkg::OFS_STATUS, 0, 1'b1);
        wait_bit(link_ctrl_pkg::OFS_STATUS, 0, 1'b0);
        rdchk(link_ctrl_pkg::OFS_PRESENT, 32'hffff_fff7);
        chk(32'(n_xfer - n0), 32'h0000_001f);
        chk(32'(last_cmd.probe), 32'h0000_0001);
        // Auto mode on a user-set address keeps cycling until cleared
        apb(1'b1, 8'h80, 32'h0000_0033);
        rdchk(8'h80, 32'h0000_0033);
        apb(1'b1, link_ctrl_pkg::OFS_CONNECT, 32'h0000_0001);
        n0 = n_xfer;
        apb(1'b1, link_ctrl_pkg::OFS_CTRL, 32'h0000_0047);
        repeat (200) @(posedge pclk);
        chk(32'(n_xfer - n0 > 16'h0002), 32'h0000_0001);
        rdchk(link_ctrl_pkg::OFS_CTRL, 32'h0000_0047);
        chk(32'(last_cmd.addr), 32'h0000_0033);
        rdchk(link_ctrl_pkg::OFS_STATUS, 32'h0000_0000);
        apb(1'b1, link_ctrl_pkg::OFS_CTRL, 32'h0000_0000);
        print_verdict();
    end
endmodule

/* verilog/link_ctrl.sv */
// Purpose: Control and status flags of a polling master with its cycle engine.
// Assumes: Exchange engine on pclk; one request open at a time.
// Notes: Registers over APB, zero wait states, read data captured in setup.

// Operation
// - Link enable flag, off at reset, starts exchange
// - Manual select uses per-slave connect flags
// - Auto mode repeats cycles while enabled
// - Manual mode runs bounded cycles then stops
// - Read-only flag shows detection running
// - Both modes on sets conflict flag
// - Invalid station address sets address error
// - Slave timeout sets flag, clean exchange clears
// - Zero cycle limit sets poll count error
// - Protocol select picks standard or extended framing
// - Detection starts only while link stopped
// - Addresses consecutive from first, or user table
// - Summary flag shows any link error
// - Port select picks extension or own port
// - Sync flag combines read and write
// - Detection skips slaves with master's address
// - Manual count reaching limit clears enable
// - One writable connect flag per slave
// - Limit legal from one to maximum, uncorrected
module link_ctrl #(
    parameter int NSLAVE = link_ctrl_pkg::NSLAVE_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output link_ctrl_pkg::xfer_cmd_t xfer_cmd,
    output logic xfer_valid,
    input wire logic xfer_done,
    input wire link_ctrl_pkg::xfer_rsp_t xfer_rsp
);

    localparam int IDX_W = (NSLAVE > 1) ? $clog2(NSLAVE) : 1;
    localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NSLAVE - 1);

    // ----------------------------------------
    // State
    // ----------------------------------------
    link_ctrl_pkg::ctrl_t ctrl;
    link_ctrl_pkg::ctrl_t next_ctrl;
    link_ctrl_pkg::status_t st;
    link_ctrl_pkg::state_t state;
    link_ctrl_pkg::state_t next_state;
    link_ctrl_pkg::xfer_cmd_t next_xfer_cmd;
    logic [7:0] first_addr;
    logic [7:0] next_first_addr;
    logic [15:0] limit;
    logic [15:0] next_limit;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [7:0] master_addr;
    logic [7:0] next_master_addr;
    logic [NSLAVE-1:0] connect;
    logic [NSLAVE-1:0] next_connect;
    logic [NSLAVE-1:0] present;
    logic [NSLAVE-1:0] next_present;
    logic [7:0] user_tab [NSLAVE];
    logic [7:0] next_user_tab [NSLAVE];
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] next_idx;
    logic addr_err;
    logic next_addr_err;
    logic tout;
    logic next_tout;
    logic [31:0] next_prdata;
    logic [31:0] rdata;
    logic stop_link;
    logic detect_done;
    logic run_ok;
    logic advance;
    logic padvance;
    logic [7:0] pick_addr;
    logic pick_ok;
    logic wr;
    logic wr_ctrl;
    logic [IDX_W-1:0] tab_idx;
    logic tab_hit;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        logic tab;
        tab = a[7] && (a[1:0] == 2'h0) && (32'(a[6:2]) < NSLAVE);
        return tab || (a inside {link_ctrl_pkg::OFS_CTRL, link_ctrl_pkg::OFS_STATUS,
            link_ctrl_pkg::OFS_FIRST, link_ctrl_pkg::OFS_LIMIT, link_ctrl_pkg::OFS_COUNT,
            link_ctrl_pkg::OFS_CONNECT, link_ctrl_pkg::OFS_MASTER,
            link_ctrl_pkg::OFS_PRESENT});
    endfunction

    assign pready = 1'h1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign wr = psel && penable && pwrite && is_mapped(paddr);
    assign wr_ctrl = wr && (paddr == link_ctrl_pkg::OFS_CTRL);
    assign tab_idx = IDX_W'(paddr[6:2]);
    assign tab_hit = paddr[7] && (paddr[1:0] == 2'h0);

    // ----------------------------------------
    // Status view
    // ----------------------------------------
    always_comb begin
        st.detect_in_progress = (state == link_ctrl_pkg::ST_PROBE) ||
            (state == link_ctrl_pkg::ST_PWAIT);
        st.mode_conflict_error = ctrl.auto_mode_flag && ctrl.manual_mode_flag;
        st.address_error_flag = addr_err;
        st.timeout_flag = tout;
        st.poll_count_error = (limit == link_ctrl_pkg::LIMIT_ZERO);
        st.link_error_summary = st.mode_conflict_error || addr_err || tout ||
            st.poll_count_error;
    end

    always_comb begin
        rdata = 32'h0000_0000;
        if (tab_hit) begin
            rdata = 32'(user_tab[tab_idx]);
        end else begin
            unique case (paddr)
                link_ctrl_pkg::OFS_CTRL: begin
                    rdata = 32'(ctrl);
                    // Request bit reads as running, not as pending
                    rdata[5] = st.detect_in_progress;
                end
                link_ctrl_pkg::OFS_STATUS: rdata = 32'(st);
                link_ctrl_pkg::OFS_FIRST: rdata = 32'(first_addr);
                link_ctrl_pkg::OFS_LIMIT: rdata = 32'(limit);
                link_ctrl_pkg::OFS_COUNT: rdata = 32'(count);
                link_ctrl_pkg::OFS_CONNECT: rdata = 32'(connect);
                link_ctrl_pkg::OFS_MASTER: rdata = 32'(master_addr);
                link_ctrl_pkg::OFS_PRESENT: rdata = 32'(present);
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Register group
    // ----------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_first_addr = first_addr;
        next_limit = limit;
        next_master_addr = master_addr;
        next_connect = connect;
        next_user_tab = user_tab;
        next_prdata = prdata;
        if (psel && !penable) begin
            next_prdata = rdata;
        end
        // Status, count and presence words have no write path
        if (wr) begin
            if (tab_hit) begin
                next_user_tab[tab_idx] = pwdata[7:0];
            end else if (paddr == link_ctrl_pkg::OFS_CTRL) begin
                next_ctrl = link_ctrl_pkg::ctrl_t'(pwdata[8:0]);
            end else if (paddr == link_ctrl_pkg::OFS_FIRST) begin
                next_first_addr = pwdata[7:0];
            end else if (paddr == link_ctrl_pkg::OFS_LIMIT) begin
                next_limit = pwdata[15:0];
            end else if (paddr == link_ctrl_pkg::OFS_CONNECT) begin
                next_connect = pwdata[NSLAVE-1:0];
            end else if (paddr == link_ctrl_pkg::OFS_MASTER) begin
                next_master_addr = pwdata[7:0];
            end
        end
        // Pending request is sticky; a new write beats the done clear
        next_ctrl.auto_detect_request = (ctrl.auto_detect_request && !detect_done) ||
            (wr_ctrl && pwdata[5]);
        if (ctrl.auto_mode_flag && ctrl.manual_mode_flag && !wr_ctrl) begin
            next_ctrl.link_enable_flag = 1'h0;
        end
        if ((limit == link_ctrl_pkg::LIMIT_ZERO) && ctrl.manual_mode_flag && !wr_ctrl) begin
            next_ctrl.manual_mode_flag = 1'h0;
        end
        // Limit stop wins over a software write in the same cycle
        if (stop_link) begin
            next_ctrl.link_enable_flag = 1'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= link_ctrl_pkg::CTRL_RESET;
            first_addr <= link_ctrl_pkg::FIRST_RESET;
            limit <= link_ctrl_pkg::LIMIT_RESET;
            master_addr <= link_ctrl_pkg::MASTER_RESET;
            connect <= '0;
            user_tab <= '{default: link_ctrl_pkg::TABLE_RESET};
            prdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            first_addr <= next_first_addr;
            limit <= next_limit;
            master_addr <= next_master_addr;
            connect <= next_connect;
            user_tab <= next_user_tab;
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // Slot decode
    // ----------------------------------------
    slave_pick #(
        .IDX_W(IDX_W)
    ) u_pick (
        .idx(idx),
        .first_addr(first_addr),
        .user_addr(user_tab[idx]),
        .assign_select(ctrl.address_assign_select),
        .manual_select(ctrl.manual_connect_select),
        .connect_bit(connect[idx]),
        .present_bit(present[idx]),
        .addr(pick_addr),
        .eligible(pick_ok)
    );

    // ----------------------------------------
    // Cycle engine
    // ----------------------------------------
    assign run_ok = ctrl.link_enable_flag && (ctrl.auto_mode_flag ^ ctrl.manual_mode_flag) &&
        !(ctrl.manual_mode_flag && (limit == link_ctrl_pkg::LIMIT_ZERO));
    assign xfer_valid = (state == link_ctrl_pkg::ST_WAIT) || (state == link_ctrl_pkg::ST_PWAIT);

    always_comb begin
        next_state = state;
        next_idx = idx;
        next_count = count;
        next_addr_err = addr_err;
        next_tout = tout;
        next_present = present;
        next_xfer_cmd = xfer_cmd;
        stop_link = 1'h0;
        detect_done = 1'h0;
        advance = 1'h0;
        padvance = 1'h0;
        unique case (state)
            link_ctrl_pkg::ST_IDLE: begin
                if (run_ok) begin
                    next_idx = '0;
                    next_state = link_ctrl_pkg::ST_ISSUE;
                    if (ctrl.manual_mode_flag) begin
                        next_count = link_ctrl_pkg::LIMIT_ZERO;
                    end
                end else if (ctrl.auto_detect_request && !ctrl.link_enable_flag) begin
                    next_idx = '0;
                    next_state = link_ctrl_pkg::ST_PROBE;
                end
            end
            link_ctrl_pkg::ST_ISSUE: begin
                if (!run_ok) begin
                    next_state = link_ctrl_pkg::ST_IDLE;
                end else if (pick_ok) begin
                    next_xfer_cmd.addr = pick_addr;
                    next_xfer_cmd.probe = 1'h0;
                    next_xfer_cmd.sync = ctrl.sync_exchange_enable;
                    next_xfer_cmd.protocol = ctrl.protocol_select;
                    next_xfer_cmd.ext_port = ctrl.extension_port_select;
                    next_state = link_ctrl_pkg::ST_WAIT;
                end else begin
                    advance = 1'h1;
                end
            end
            link_ctrl_pkg::ST_WAIT: begin
                if (xfer_done) begin
                    next_addr_err = xfer_rsp.addr_err;
                    next_tout = xfer_rsp.timeout;
                    next_state = link_ctrl_pkg::ST_ISSUE;
                    advance = 1'h1;
                end
            end
            link_ctrl_pkg::ST_PROBE: begin
                if (pick_addr == master_addr) begin
                    next_present[idx] = 1'h0;
                    padvance = 1'h1;
                end else begin
                    next_xfer_cmd.addr = pick_addr;
                    next_xfer_cmd.probe = 1'h1;
                    next_xfer_cmd.sync = 1'h0;
                    next_xfer_cmd.protocol = ctrl.protocol_select;
                    next_xfer_cmd.ext_port = ctrl.extension_port_select;
                    next_state = link_ctrl_pkg::ST_PWAIT;
                end
            end
            link_ctrl_pkg::ST_PWAIT: begin
                if (xfer_done) begin
                    next_present[idx] = xfer_rsp.present;
                    next_state = link_ctrl_pkg::ST_PROBE;
                    padvance = 1'h1;
                end
            end
            default: next_state = link_ctrl_pkg::ST_IDLE;
        endcase
        if (advance) begin
            if (idx != IDX_LAST) begin
                next_idx = IDX_W'(idx + IDX_W'(1));
            end else begin
                next_idx = '0;
                if (ctrl.manual_mode_flag) begin
                    next_count = 16'(count + link_ctrl_pkg::COUNT_STEP);
                    if (next_count == limit) begin
                        stop_link = 1'h1;
                        next_state = link_ctrl_pkg::ST_IDLE;
                    end
                end
            end
        end
        if (padvance) begin
            if (idx != IDX_LAST) begin
                next_idx = IDX_W'(idx + IDX_W'(1));
            end else begin
                detect_done = 1'h1;
                next_state = link_ctrl_pkg::ST_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= link_ctrl_pkg::ST_IDLE;
            idx <= '0;
            count <= link_ctrl_pkg::LIMIT_ZERO;
            addr_err <= 1'h0;
            tout <= 1'h0;
            // Until a detection pass, every slot counts as assigned
            present <= '1;
            xfer_cmd <= '0;
        end else begin
            state <= next_state;
            idx <= next_idx;
            count <= next_count;
            addr_err <= next_addr_err;
            tout <= next_tout;
            present <= next_present;
            xfer_cmd <= next_xfer_cmd;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_issue_needs_enable;
        @(posedge pclk) disable iff (!presetn)
        (state == link_ctrl_pkg::ST_ISSUE && next_state == link_ctrl_pkg::ST_WAIT)
            |-> ctrl.link_enable_flag;
    endproperty
    a_issue_needs_enable: assert property (p_issue_needs_enable)
        else $error("exchange issued with link disabled");

    property p_manual_connect;
        @(posedge pclk) disable iff (!presetn)
        (state == link_ctrl_pkg::ST_ISSUE && next_state == link_ctrl_pkg::ST_WAIT &&
            ctrl.manual_connect_select) |=> !xfer_cmd.probe && connect[idx];
    endproperty
    a_manual_connect: assert property (p_manual_connect)
        else $error("unselected slave contacted");

    property p_conflict_stops;
        @(posedge pclk) disable iff (!presetn)
        (st.mode_conflict_error && !wr_ctrl) |=> !ctrl.link_enable_flag;
    endproperty
    a_conflict_stops: assert property (p_conflict_stops)
        else $error("mode conflict left link enabled");

    property p_wait_flags;
        @(posedge pclk) disable iff (!presetn)
        (state == link_ctrl_pkg::ST_WAIT && xfer_done) |=>
            (st.timeout_flag == $past(xfer_rsp.timeout)) &&
            (st.address_error_flag == $past(xfer_rsp.addr_err));
    endproperty
    a_wait_flags: assert property (p_wait_flags)
        else $error("exchange result not reflected in flags");

    property p_zero_limit;
        @(posedge pclk) disable iff (!presetn)
        (limit == link_ctrl_pkg::LIMIT_ZERO && !wr_ctrl) |->
            st.poll_count_error ##1 !ctrl.manual_mode_flag;
    endproperty
    a_zero_limit: assert property (p_zero_limit)
        else $error("zero limit not flagged");

    property p_detect_stopped;
        @(posedge pclk) disable iff (!presetn)
        (state == link_ctrl_pkg::ST_IDLE && next_state == link_ctrl_pkg::ST_PROBE)
            |-> !ctrl.link_enable_flag ##1 st.detect_in_progress;
    endproperty
    a_detect_stopped: assert property (p_detect_stopped)
        else $error("detection started while link running");

    property p_consecutive_addr;
        @(posedge pclk) disable iff (!presetn)
        (state == link_ctrl_pkg::ST_WAIT && !ctrl.address_assign_select &&
            $past(state) == link_ctrl_pkg::ST_ISSUE) |->
            xfer_cmd.addr == 8'(first_addr + 8'(idx));
    endproperty
    a_consecutive_addr: assert property (p_consecutive_addr)
        else $error("slave address not consecutive");

    property p_skip_master;
        @(posedge pclk) disable iff (!presetn)
        (state == link_ctrl_pkg::ST_PWAIT) |-> xfer_cmd.addr != master_addr;
    endproperty
    a_skip_master: assert property (p_skip_master)
        else $error("probe sent to master station address");

    property p_limit_stop;
        @(posedge pclk) disable iff (!presetn)
        stop_link |=> !ctrl.link_enable_flag && (count == limit) &&
            (state == link_ctrl_pkg::ST_IDLE);
    endproperty
    a_limit_stop: assert property (p_limit_stop)
        else $error("limit reached but link kept running");

endmodule

/* verilog/link_ctrl_pkg.sv */
// Purpose: Shared constants and types of the polling-link control flags.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Field layouts are carried by the packed structs below.
package link_ctrl_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam int STATION_W = 8;
    localparam int LIMIT_W = 16;
    localparam int NSLAVE_DEF = 32;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_FIRST = 8'h08;
    localparam logic [7:0] OFS_LIMIT = 8'h0c;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_CONNECT = 8'h14;
    localparam logic [7:0] OFS_MASTER = 8'h18;
    localparam logic [7:0] OFS_PRESENT = 8'h1c;
    localparam logic [7:0] OFS_TABLE = 8'h80;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam logic [7:0] FIRST_RESET = 8'h02;
    localparam logic [15:0] LIMIT_RESET = 16'h0001;
    localparam logic [15:0] LIMIT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [7:0] MASTER_RESET = 8'h01;
    localparam logic [7:0] TABLE_RESET = 8'h00;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic sync_exchange_enable;
        logic extension_port_select;
        logic address_assign_select;
        logic auto_detect_request;
        logic protocol_select;
        logic manual_mode_flag;
        logic auto_mode_flag;
        logic manual_connect_select;
        logic link_enable_flag;
    } ctrl_t;

    typedef struct packed {
        logic link_error_summary;
        logic poll_count_error;
        logic timeout_flag;
        logic address_error_flag;
        logic mode_conflict_error;
        logic detect_in_progress;
    } status_t;

    typedef struct packed {
        logic [7:0] addr;
        logic probe;
        logic sync;
        logic protocol;
        logic ext_port;
    } xfer_cmd_t;

    typedef struct packed {
        logic timeout;
        logic addr_err;
        logic present;
    } xfer_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ISSUE = 3'h1,
        ST_WAIT = 3'h2,
        ST_PROBE = 3'h3,
        ST_PWAIT = 3'h4
    } state_t;

endpackage

/* verilog/slave_pick.sv */
// Purpose: Station address and eligibility of one slave slot.
// Assumes: Inputs come from registers on the same clock.
// Notes: Pure combinational decode.
module slave_pick #(
    parameter int IDX_W = 5
) (
    input wire logic [IDX_W-1:0] idx,
    input wire logic [7:0] first_addr,
    input wire logic [7:0] user_addr,
    input wire logic assign_select,
    input wire logic manual_select,
    input wire logic connect_bit,
    input wire logic present_bit,
    output logic [7:0] addr,
    output logic eligible
);

    // ----------------------------------------
    // Address and connect choice
    // ----------------------------------------
    always_comb begin
        if (assign_select) begin
            addr = user_addr;
        end else begin
            addr = 8'(first_addr + 8'(idx));
        end
        // Connect flag counts under manual selection, presence flag otherwise
        eligible = manual_select ? connect_bit : present_bit;
    end

endmodule
